/* qwp_pkg.sv */
// constants shared by both ends of the quad wiper serial link
// =====================================================================
// Overview of operation
// RULE1: four 8-bit wiper registers, 00h low end
// RULE2: all wipers reset to 80h
// RULE3: selector 00h-03h picks wiper 0-3
// RULE4: master starts transfers and makes clock
// RULE5: bytes go most significant bit first
// RULE6: data moves only while clock low
// RULE7: device leaves data pin released until addressed
// RULE8: device ignores everything until a START
// RULE9: STOP ends every operation, device idles
// RULE10: receiver pulls data low on ninth clock
// RULE11: id byte is 01010, pins, direction
// RULE12: device acks id, selector, write data
// RULE13: master acks each read byte for more
// RULE14: write is START, id, selector, data, STOP
// RULE15: read sets selector, repeated START, read id
// RULE16: device sends while acked; master then STOPs
// RULE17: read pointer advances, wraps 03h to 00h
// RULE18: pulses under 50 ns are ignored
// RULE19: unmatched id gets no ack, waits START
// RULE20: write data loads wiper at its ack
package qwp_pkg;
  // =====================================================================
  // timing
  localparam int         CLK_NS        = 40;
  localparam int         GLITCH_NS     = 50;
  localparam int         GLITCH_CYC    = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] GLITCH_LAST   = 2'(GLITCH_CYC - 1);
  localparam int         SCL_PERIOD_NS = 2500;
  localparam int         SCL_PHASES    = 4;
  localparam int         SCL_QTR_CYC   = (SCL_PERIOD_NS + SCL_PHASES * CLK_NS - 1) / (SCL_PHASES * CLK_NS);
  // =====================================================================
  // device map
  localparam int         NUM_POT       = 4;
  localparam logic [7:0] SEL_LIMIT     = 8'h04;
  localparam logic [7:0] WIPER_RESET   = 8'h80;
  localparam logic [4:0] ID_PREFIX     = 5'h0A;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic       DIR_READ      = 1'h1;
  localparam logic       DIR_WRITE     = 1'h0;
  // =====================================================================
  // controller registers
  localparam logic [3:0] HREG_CTRL     = 4'h0;
  localparam logic [3:0] HREG_SEL      = 4'h1;
  localparam logic [3:0] HREG_WDATA    = 4'h2;
  localparam logic [3:0] HREG_STATUS   = 4'h3;
  localparam logic [3:0] HREG_RXBUF    = 4'h4;
  localparam int         CTRL_GO       = 0;
  localparam int         CTRL_READ     = 1;
  localparam int         CTRL_CNT      = 2;
  localparam int         CTRL_TGT      = 4;
endpackage

/* qwp_if.sv */
// open-drain serial link joining the controller and the device
`timescale 1ns/100ps
interface qwp_if;
  // =====================================================================
  // drivers, enable low means pulling
  logic hostSclOeN;
  logic hostSclOut;
  logic hostSdaOeN;
  logic hostSdaOut;
  logic devSdaOeN;
  logic devSdaOut;
  // =====================================================================
  // resolved lines with pull-up
  logic scl;
  logic sda;
  assign scl = hostSclOeN | hostSclOut;
  assign sda = (hostSdaOeN | hostSdaOut) & (devSdaOeN | devSdaOut);
  modport device (input scl, input sda, output devSdaOeN, output devSdaOut);
  modport host (input sda, output hostSclOeN, output hostSclOut, output hostSdaOeN, output hostSdaOut);
endinterface

/* qwp_device.sv */
// quad wiper register slave end of the serial link
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
module qwp_device (
  // serial link
  qwp_if.device       link,
  // clock and reset
  input  wire logic   mclk,
  input  wire logic   reset_n,
  // address select pins
  input  wire logic   addressSelectLow,
  input  wire logic   addressSelectHigh,
  // wiper positions
  output logic [7:0]  wiperPos [qwp_pkg::NUM_POT]
);

  typedef enum {D_IDLE, D_ID, D_SEL, D_WR, D_TX, D_WAIT} qwp_dst_t;

  // =====================================================================
  // pin synchronisers
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [3:0] pinRaw;

  assign pinRaw = {addressSelectHigh, addressSelectLow, link.sda, link.scl};

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= 4'hF;
      sync2_r <= 4'hF;
    end else begin
      sync1_r <= pinRaw;
      sync2_r <= sync1_r;
    end
  end

  // =====================================================================
  // glitch filters on clock and data
  logic [1:0] filt;
  logic [1:0] prev_r;

  for (genvar i = 0; i < 2; i++) begin : g_flt
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic       flt_r;
    logic       flt_nxt;
    always_comb begin
      cnt_nxt = 2'h0;
      flt_nxt = flt_r;
      if (sync2_r[i] != flt_r) begin
        cnt_nxt = cnt_r + 2'h1;
        if (cnt_r == qwp_pkg::GLITCH_LAST) begin
          flt_nxt = sync2_r[i]; // RULE18
          cnt_nxt = 2'h0;
        end
      end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        cnt_r <= 2'h0;
        flt_r <= 1'h1;
      end else begin
        cnt_r <= cnt_nxt;
        flt_r <= flt_nxt;
      end
    end
    assign filt[i] = flt_r;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prev_r <= 2'h3;
    end else begin
      prev_r <= filt;
    end
  end

  // =====================================================================
  // bus events
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic sdaF;

  assign sdaF      = filt[1];
  assign sclRise   = filt[0] & ~prev_r[0];
  assign sclFall   = ~filt[0] & prev_r[0];
  assign startSeen = filt[0] & prev_r[0] & prev_r[1] & ~sdaF; // RULE6
  assign stopSeen  = filt[0] & prev_r[0] & ~prev_r[1] & sdaF; // RULE6

  // =====================================================================
  // protocol engine
  qwp_dst_t   st_r;
  qwp_dst_t   st_nxt;
  logic [3:0] bit_r;
  logic [3:0] bit_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic       ack_r;
  logic       ack_nxt;
  logic       drv_r;
  logic       drv_nxt;
  logic       rd_r;
  logic       rd_nxt;
  logic       mack_r;
  logic       mack_nxt;
  logic [1:0] ptr_r;
  logic [1:0] ptr_nxt;
  logic [1:0] ptrInc;
  logic [7:0] wip_r [qwp_pkg::NUM_POT];
  logic [7:0] wip_nxt [qwp_pkg::NUM_POT];
  logic [6:0] idMatch;

  assign ptrInc  = ptr_r + 2'h1; // RULE17
  assign idMatch = {qwp_pkg::ID_PREFIX, sync2_r[3], sync2_r[2]};

  always_comb begin
    st_nxt   = st_r;
    bit_nxt  = bit_r;
    sh_nxt   = sh_r;
    ack_nxt  = ack_r;
    drv_nxt  = drv_r;
    rd_nxt   = rd_r;
    mack_nxt = mack_r;
    ptr_nxt  = ptr_r;
    wip_nxt  = wip_r;
    if (stopSeen) begin
      st_nxt  = D_IDLE; // RULE9
      drv_nxt = 1'h0;
      ack_nxt = 1'h0;
    end else if (startSeen) begin
      st_nxt  = D_ID; // RULE8
      bit_nxt = 4'h0;
      drv_nxt = 1'h0;
      ack_nxt = 1'h0;
    end else if (st_r != D_IDLE && st_r != D_WAIT) begin
      if (sclRise) begin
        if (ack_r) begin
          mack_nxt = ~sdaF; // RULE13
        end else begin
          bit_nxt = bit_r + 4'h1;
          if (st_r != D_TX) begin
            sh_nxt = {sh_r[6:0], sdaF}; // RULE5
          end
        end
      end else if (sclFall) begin
        if (ack_r) begin
          ack_nxt = 1'h0;
          drv_nxt = 1'h0; // RULE10
          bit_nxt = 4'h0;
          case (st_r)
            D_ID: begin
              if (rd_r) begin
                st_nxt  = D_TX;
                sh_nxt  = wip_r[ptr_r];
                drv_nxt = ~wip_r[ptr_r][7]; // RULE5
              end else begin
                st_nxt = D_SEL;
              end
            end
            D_SEL: begin
              st_nxt = D_WR;
            end
            D_TX: begin
              if (mack_r) begin
                ptr_nxt = ptrInc; // RULE17
                sh_nxt  = wip_r[ptrInc];
                drv_nxt = ~wip_r[ptrInc][7]; // RULE16
              end else begin
                st_nxt = D_WAIT; // RULE16
              end
            end
            default: begin
              st_nxt = D_WAIT; // RULE14
            end
          endcase
        end else if (bit_r == qwp_pkg::BYTE_BITS) begin
          ack_nxt = 1'h1;
          drv_nxt = (st_r != D_TX); // RULE12
          case (st_r)
            D_ID: begin
              if (sh_r[7:1] == idMatch) begin // RULE11
                rd_nxt = sh_r[0];
              end else begin
                ack_nxt = 1'h0; // RULE19
                drv_nxt = 1'h0;
                st_nxt  = D_WAIT;
              end
            end
            D_SEL: begin
              if (sh_r < qwp_pkg::SEL_LIMIT) begin
                ptr_nxt = sh_r[1:0]; // RULE3
              end else begin
                ack_nxt = 1'h0;
                drv_nxt = 1'h0;
                st_nxt  = D_WAIT;
              end
            end
            D_WR: begin
              wip_nxt[ptr_r] = sh_r; // RULE20
            end
            default: begin
              drv_nxt = 1'h0; // RULE10
            end
          endcase
        end else if (st_r == D_TX) begin
          sh_nxt  = {sh_r[6:0], 1'h0};
          drv_nxt = ~sh_r[6]; // RULE5
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_r   <= D_IDLE;
      bit_r  <= 4'h0;
      sh_r   <= 8'h00;
      ack_r  <= 1'h0;
      drv_r  <= 1'h0; // RULE7
      rd_r   <= 1'h0;
      mack_r <= 1'h0;
      ptr_r  <= 2'h0;
      for (int i = 0; i < qwp_pkg::NUM_POT; i++) begin
        wip_r[i] <= qwp_pkg::WIPER_RESET; // RULE2
      end
    end else begin
      st_r   <= st_nxt;
      bit_r  <= bit_nxt;
      sh_r   <= sh_nxt;
      ack_r  <= ack_nxt;
      drv_r  <= drv_nxt;
      rd_r   <= rd_nxt;
      mack_r <= mack_nxt;
      ptr_r  <= ptr_nxt;
      wip_r  <= wip_nxt;
    end
  end

  // =====================================================================
  // outputs
  logic sdaLow_r;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sdaLow_r <= 1'h0;
    end else begin
      sdaLow_r <= 1'h0;
    end
  end

  assign link.devSdaOeN = ~drv_r; // RULE4
  assign link.devSdaOut = sdaLow_r;
  assign wiperPos       = wip_r; // RULE1

endmodule

/* qwp_host.sv */
// controller end of the serial link, driven from a small register port
`timescale 1ns/100ps
module qwp_host #(
  parameter int QTR_CYC = qwp_pkg::SCL_QTR_CYC
) (
  // serial link
  qwp_if.host         link,
  // clock and reset
  input  wire logic   mclk,
  input  wire logic   reset_n,
  // register port
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic   regWr,
  input  wire logic   regRd,
  output logic [7:0]  regRdata
);

  typedef enum {H_IDLE, H_START, H_TX, H_RX, H_STOP} qwp_hst_t;

  // =====================================================================
  // data line synchroniser
  logic sda1_r;
  logic sdaS_r;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sda1_r <= 1'h1;
      sdaS_r <= 1'h1;
    end else begin
      sda1_r <= link.sda;
      sdaS_r <= sda1_r;
    end
  end

  // =====================================================================
  // sequencer and registers
  qwp_hst_t   st_r, st_nxt;
  logic [7:0] qcnt_r, qcnt_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [2:0] step_r, step_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic [7:0] rx_r, rx_nxt;
  logic [1:0] rdIdx_r, rdIdx_nxt;
  logic       nack_r, nack_nxt;
  logic       rdMode_r, rdMode_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic [1:0] tgt_r, tgt_nxt;
  logic [7:0] sel_r, sel_nxt;
  logic [7:0] wdat_r, wdat_nxt;
  logic [7:0] rxBuf_r [4];
  logic [7:0] rxBuf_nxt [4];
  logic       sclOeN_r, sclOeN_nxt;
  logic       sdaOeN_r, sdaOeN_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       tick;
  logic [2:0] stepInc;

  assign tick    = (qcnt_r == 8'(QTR_CYC - 1));
  assign stepInc = step_r + 3'h1;

  always_comb begin
    st_nxt = st_r; qcnt_nxt = 8'h00; ph_nxt = ph_r; bit_nxt = bit_r;
    step_nxt = step_r; tx_nxt = tx_r; rx_nxt = rx_r; rdIdx_nxt = rdIdx_r;
    nack_nxt = nack_r; rdMode_nxt = rdMode_r; cnt_nxt = cnt_r; tgt_nxt = tgt_r;
    sel_nxt = sel_r; wdat_nxt = wdat_r; rxBuf_nxt = rxBuf_r;
    sclOeN_nxt = sclOeN_r; sdaOeN_nxt = sdaOeN_r; rdata_nxt = 8'h00;
    if (regRd) begin
      if (regAddr == qwp_pkg::HREG_CTRL) begin
        rdata_nxt = {2'h0, tgt_r, cnt_r, rdMode_r, 1'h0};
      end else if (regAddr == qwp_pkg::HREG_SEL) begin
        rdata_nxt = sel_r;
      end else if (regAddr == qwp_pkg::HREG_WDATA) begin
        rdata_nxt = wdat_r;
      end else if (regAddr == qwp_pkg::HREG_STATUS) begin
        rdata_nxt = {6'h00, nack_r, st_r != H_IDLE};
      end else if (regAddr[3:2] == qwp_pkg::HREG_RXBUF[3:2]) begin
        rdata_nxt = rxBuf_r[regAddr[1:0]];
      end
    end
    if (regWr && st_r == H_IDLE) begin
      if (regAddr == qwp_pkg::HREG_SEL) begin
        sel_nxt = regWdata;
      end else if (regAddr == qwp_pkg::HREG_WDATA) begin
        wdat_nxt = regWdata;
      end else if (regAddr == qwp_pkg::HREG_CTRL) begin
        rdMode_nxt = regWdata[qwp_pkg::CTRL_READ];
        cnt_nxt    = regWdata[qwp_pkg::CTRL_CNT +: 2];
        tgt_nxt    = regWdata[qwp_pkg::CTRL_TGT +: 2];
        if (regWdata[qwp_pkg::CTRL_GO]) begin
          st_nxt = H_START; // RULE4
          ph_nxt = 2'h0; step_nxt = 3'h0; nack_nxt = 1'h0; rdIdx_nxt = 2'h0;
          sclOeN_nxt = 1'h0;
        end
      end
    end
    if (st_r != H_IDLE) begin
      qcnt_nxt = tick ? 8'h00 : qcnt_r + 8'h01;
      if (tick) begin
        ph_nxt = ph_r + 2'h1;
        if (ph_r == 2'h3) begin
          if (st_r == H_TX || st_r == H_RX) begin
            bit_nxt = bit_r + 4'h1;
            if (st_r == H_TX) begin
              tx_nxt = {tx_r[6:0], 1'h0}; // RULE5
            end else if (bit_r != qwp_pkg::BYTE_BITS) begin
              rx_nxt = {rx_r[6:0], sdaS_r}; // RULE5
            end
          end
          if ((st_r != H_TX && st_r != H_RX) || bit_r == qwp_pkg::BYTE_BITS) begin
            bit_nxt = 4'h0; step_nxt = stepInc;
            st_nxt = H_STOP; // RULE9
            if (st_r == H_STOP) begin
              st_nxt = H_IDLE;
            end else if (st_r == H_TX && sdaS_r) begin
              nack_nxt = 1'h1;
            end else if (st_r == H_RX && rdIdx_r != cnt_r) begin
              rxBuf_nxt[rdIdx_r] = rx_r;
              rdIdx_nxt = rdIdx_r + 2'h1; step_nxt = step_r; st_nxt = H_RX; // RULE13
            end else begin
              if (st_r == H_RX) begin
                rxBuf_nxt[rdIdx_r] = rx_r; // RULE16
              end
              case (stepInc)
                3'h1: begin st_nxt = H_TX; tx_nxt = {qwp_pkg::ID_PREFIX, tgt_r, qwp_pkg::DIR_WRITE}; end // RULE11
                3'h2: begin st_nxt = H_TX; tx_nxt = sel_r; end // RULE3
                3'h3: begin
                  st_nxt = rdMode_r ? H_START : H_TX; // RULE15
                  tx_nxt = wdat_r; // RULE14
                end
                3'h4: if (rdMode_r) begin st_nxt = H_TX; tx_nxt = {qwp_pkg::ID_PREFIX, tgt_r, qwp_pkg::DIR_READ}; end
                3'h5: if (rdMode_r) st_nxt = H_RX;
                default: st_nxt = H_STOP;
              endcase
            end
          end
        end
        case (ph_nxt)
          2'h0: sclOeN_nxt = (st_nxt == H_IDLE); // RULE9
          2'h1: begin // RULE6
            if (st_r == H_START) sdaOeN_nxt = 1'h1;
            else if (st_r == H_STOP) sdaOeN_nxt = 1'h0;
            else if (bit_r == qwp_pkg::BYTE_BITS) sdaOeN_nxt = (st_r == H_TX) || (rdIdx_r == cnt_r); // RULE10
            else sdaOeN_nxt = (st_r == H_RX) || tx_r[7];
          end
          2'h2: sclOeN_nxt = 1'h1;
          default: begin
            if (st_r == H_START) sdaOeN_nxt = 1'h0;
            else if (st_r == H_STOP) sdaOeN_nxt = 1'h1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= H_IDLE; qcnt_r <= 8'h00; ph_r <= 2'h0; bit_r <= 4'h0;
      step_r <= 3'h0; tx_r <= 8'h00; rx_r <= 8'h00; rdIdx_r <= 2'h0;
      nack_r <= 1'h0; rdMode_r <= 1'h0; cnt_r <= 2'h0; tgt_r <= 2'h0;
      sel_r <= 8'h00; wdat_r <= 8'h00;
      for (int i = 0; i < 4; i++) begin
        rxBuf_r[i] <= 8'h00;
      end
      sclOeN_r <= 1'h1; sdaOeN_r <= 1'h1; rdata_r <= 8'h00;
    end else begin
      st_r <= st_nxt; qcnt_r <= qcnt_nxt; ph_r <= ph_nxt; bit_r <= bit_nxt;
      step_r <= step_nxt; tx_r <= tx_nxt; rx_r <= rx_nxt; rdIdx_r <= rdIdx_nxt;
      nack_r <= nack_nxt; rdMode_r <= rdMode_nxt; cnt_r <= cnt_nxt; tgt_r <= tgt_nxt;
      sel_r <= sel_nxt; wdat_r <= wdat_nxt; rxBuf_r <= rxBuf_nxt;
      sclOeN_r <= sclOeN_nxt; sdaOeN_r <= sdaOeN_nxt; rdata_r <= rdata_nxt;
    end
  end

  // =====================================================================
  // outputs, open drain pulls low only
  logic low_r;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      low_r <= 1'h0;
    end else begin
      low_r <= 1'h0;
    end
  end

  assign link.hostSclOeN = sclOeN_r;
  assign link.hostSclOut = low_r;
  assign link.hostSdaOeN = sdaOeN_r;
  assign link.hostSdaOut = low_r;
  assign regRdata        = rdata_r;

endmodule

/* qwp_assertions.sv */
// checker of the serial link wires between both ends
`timescale 1ns/100ps
module qwp_assertions (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // link signals
  input wire logic scl,
  input wire logic sda,
  input wire logic hostSclOeN,
  input wire logic hostSdaOeN,
  input wire logic devSdaOeN,
  input wire logic devSdaOut
);
  // =====================================================================
  // frame tracking
  logic sclPrev_r;
  logic sclPrev_nxt;
  logic sdaPrev_r;
  logic sdaPrev_nxt;
  logic inFrame_r;
  logic inFrame_nxt;
  logic startSeen;
  logic stopSeen;

  always_comb begin
    startSeen   = scl & sclPrev_r & sdaPrev_r & ~sda;
    stopSeen    = scl & sclPrev_r & ~sdaPrev_r & sda;
    sclPrev_nxt = scl;
    sdaPrev_nxt = sda;
    inFrame_nxt = startSeen ? 1'b1 : (stopSeen ? 1'b0 : inFrame_r);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
      inFrame_r <= 1'b0;
    end else begin
      sclPrev_r <= sclPrev_nxt;
      sdaPrev_r <= sdaPrev_nxt;
      inFrame_r <= inFrame_nxt;
    end
  end

  // =====================================================================
  // link properties
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_dev_sda_moves: assert property ($changed(devSdaOeN) |-> !scl)
    else $error("device data changed while clock high");
  a_dev_hold_high: assert property ($rose(scl) |=> $stable(devSdaOeN) [*8])
    else $error("device data not held over clock high");
  a_ack_hold: assert property ($fell(devSdaOeN) |=> !devSdaOeN [*8])
    else $error("device low drive too short");
  a_dev_in_frame: assert property (!devSdaOeN |-> inFrame_r)
    else $error("device drove data outside a frame");
  a_start_released: assert property (startSeen |-> devSdaOeN)
    else $error("device drove data at start");
  a_stop_standby: assert property (stopSeen |-> devSdaOeN [*8])
    else $error("device not idle after stop");
  a_host_yields: assert property (!devSdaOeN && scl |-> hostSdaOeN)
    else $error("host drove data while device sends");
  a_dev_opendrain: assert property (devSdaOut == 1'b0)
    else $error("device data drive value not low");
  a_scl_high_phase: assert property ($rose(hostSclOeN) |-> scl [*8])
    else $error("clock high phase too short");
endmodule

/* tb_quad_wiper_i2c_slave.sv */
// self-checking bench joining controller and device over the link
`timescale 1ns/100ps
module tb_quad_wiper_i2c_slave;
  // =====================================================================
  // signals
  logic       mclk;
  logic       reset_n;
  logic       addrLow;
  logic       addrHigh;
  logic [3:0] regAddr;
  logic [7:0] regWdata;
  logic       regWr;
  logic       regRd;
  logic [7:0] regRdata;
  logic [7:0] wiperPos [qwp_pkg::NUM_POT];
  logic [7:0] expW [qwp_pkg::NUM_POT];
  logic [7:0] st;
  int         mismatches;
  int         nChecks;
  int         cycles;
  localparam logic [7:0] WV [4] = '{8'h00, 8'hFF, 8'h3C, 8'hC3};

  qwp_if linkIf ();
  qwp_device qwp_device_inst (
    .link              (linkIf),
    .mclk              (mclk),
    .reset_n           (reset_n),
    .addressSelectLow  (addrLow),
    .addressSelectHigh (addrHigh),
    .wiperPos          (wiperPos)
  );
  qwp_host #(.QTR_CYC(6)) qwp_host_inst (
    .link     (linkIf),
    .mclk     (mclk),
    .reset_n  (reset_n),
    .regAddr  (regAddr),
    .regWdata (regWdata),
    .regWr    (regWr),
    .regRd    (regRd),
    .regRdata (regRdata)
  );
  qwp_assertions qwp_assertions_inst (
    .mclk       (mclk),
    .reset_n    (reset_n),
    .scl        (linkIf.scl),
    .sda        (linkIf.sda),
    .hostSclOeN (linkIf.hostSclOeN),
    .hostSdaOeN (linkIf.hostSdaOeN),
    .devSdaOeN  (linkIf.devSdaOeN),
    .devSdaOut  (linkIf.devSdaOut)
  );

  always #20 mclk = ~mclk;

  // =====================================================================
  // tasks
  task automatic checkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
    nChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge mclk);
    regWr    <= 1'b0;
  endtask

  task automatic regRead(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge mclk);
    regRd   <= 1'b0;
    #1;
    d = regRdata;
  endtask

  task automatic runOp(input logic [7:0] sel, input logic [7:0] wd, input logic [7:0] ctrl, input logic nack);
    regWrite(qwp_pkg::HREG_SEL, sel);
    regWrite(qwp_pkg::HREG_WDATA, wd);
    regRead(qwp_pkg::HREG_SEL, st);
    checkByte("selector readback", sel, st);
    regRead(qwp_pkg::HREG_WDATA, st);
    checkByte("write data readback", wd, st);
    regWrite(qwp_pkg::HREG_CTRL, ctrl);
    st = 8'h01;
    for (int i = 0; i < 4000 && st[0] !== 1'b0; i++) regRead(qwp_pkg::HREG_STATUS, st);
    checkByte("busy flag", 8'h00, {7'h00, st[0]});
    checkByte("nack flag", {7'h00, nack}, {7'h00, st[1]});
    checkByte("idle lines", 8'h03, {6'h00, linkIf.scl, linkIf.sda});
    regRead(qwp_pkg::HREG_CTRL, st);
    checkByte("control readback", ctrl & 8'h3E, st);
  endtask

  task automatic checkWipers();
    for (int k = 0; k < qwp_pkg::NUM_POT; k++) checkByte("wiper position", expW[k], wiperPos[k]);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      end_of_test();
    end
  end

  // =====================================================================
  // main sequence
  initial begin
    mclk       = 1'b0;
    reset_n    = 1'b0;
    addrLow    = 1'b1;
    addrHigh   = 1'b0;
    regAddr    = 4'h0;
    regWdata   = 8'h00;
    regWr      = 1'b0;
    regRd      = 1'b0;
    mismatches = 0;
    nChecks    = 0;
    cycles     = 0;
    expW       = '{8'h80, 8'h80, 8'h80, 8'h80};
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (8) @(posedge mclk);
    checkWipers();
    checkByte("idle lines", 8'h03, {6'h00, linkIf.scl, linkIf.sda});
    regRead(4'h8, st);
    checkByte("unmapped read", 8'h00, st);
    $display("test reset_values done");
    for (int k = 0; k < 4; k++) begin
      runOp(8'(k), WV[k], 8'h11, 1'b0);
      expW[k] = WV[k];
      checkWipers();
    end
    $display("test wiper_writes done");
    runOp(8'h02, 8'h00, 8'h1F, 1'b0);
    for (int k = 0; k < 4; k++) begin
      regRead(4'(qwp_pkg::HREG_RXBUF + k), st);
      checkByte("read byte", expW[(k + 2) % 4], st);
    end
    runOp(8'h03, 8'h00, 8'h13, 1'b0);
    regRead(qwp_pkg::HREG_RXBUF, st);
    checkByte("single read byte", expW[3], st);
    $display("test wrapping_reads done");
    addrLow  <= 1'b0;
    addrHigh <= 1'b1;
    repeat (8) @(posedge mclk);
    runOp(8'h01, 8'h5A, 8'h11, 1'b1);
    checkWipers();
    runOp(8'h01, 8'h5A, 8'h21, 1'b0);
    expW[1] = 8'h5A;
    checkWipers();
    $display("test select_pins done");
    runOp(8'h04, 8'h77, 8'h21, 1'b1);
    checkWipers();
    $display("test bad_selector done");
    end_of_test();
  end
endmodule
